// >>> pkg/tmc_pkg.sv
// Package of register offsets, field positions, reset values and carrier types for the timer.
package tmc_pkg;
  localparam logic [1:0] ADDR_CONTROL   = 2'h0;
  localparam logic [1:0] ADDR_COUNT_LOW = 2'h1;
  localparam logic [1:0] ADDR_COUNT_HI  = 2'h2;
  localparam logic [1:0] ADDR_STATUS    = 2'h3;
  localparam int BIT_RUN_ENABLE  = 0;
  localparam int BIT_CLOCK_SRC   = 1;
  localparam int BIT_SYNC_DIS    = 2;
  localparam int BIT_TB_LO       = 3;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_PRESCALE_HI = 5;
  localparam int BIT_TB_HI       = 6;
  localparam int BIT_WIDE_ACCESS = 7;
  localparam int BIT_STAT_FLAG   = 0;
  localparam int BIT_STAT_IRQ_EN = 1;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES  = 16'hFFFF;
  localparam logic [3:0]  MODE_SPECIAL_EVENT = 4'hB;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int CLK_MHZ          = 100;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmc_bus_req_t;

  typedef struct packed {
    logic sel_unit1_this;
    logic sel_unit2_this;
  } tmc_time_base_t;
endpackage

// >>> rtl/tmc_timer.sv
// Sixteen-bit timer/counter with prescaler, byte or wide access and special event reset.
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Count up, wrap all ones to zero
// - Wrap sets flag; irq when enabled
// - Source clear: instruction clock, sync ignored
// - External: rising edges after first falling
// - Count only while run enable set
// - Wide access bit selects 16/8-bit access
// - Assign bits route time base to units
// - Prescale field divides by 1,2,4,8
// - Sync disable chooses synchronized or not
// - External input from osc or shared pin
// - Prescaler on raw input, sync after
// - Synchronized increment at Q4:Q1 boundary
// - Synchronized mode holds count in sleep
// - Unsynchronized counts in sleep, wakes processor
// - Unsynchronized increments at two phase boundaries
// - Unsynchronized mode is no time base
// - Reset input from special event trigger
// - Osc enable dedicates pins, ignores direction
// - Wide mode buffers high byte on reads
// - Only low byte write clears prescaler
// - Assign bit plus mode 1011 resets
// - Write wins over special event reset
//
// The implementer's own choices: the strobed register port and the placing of the registers.
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int CLK_PER_PHASE = 1
) (
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire tmc_pkg::tmc_bus_req_t bus_req,
  output logic [7:0]                 bus_rdata,
  input  wire logic                  aux_osc_enable,
  input  wire logic                  aux_osc_input_pin,
  input  wire logic                  shared_count_clock_pin,
  input  wire logic                  sleep_mode,
  input  wire logic                  overflow_flag_clear,
  input  wire logic [3:0]            unit1_mode_field,
  input  wire logic [3:0]            unit2_mode_field,
  input  wire logic                  unit1_event,
  input  wire logic                  unit2_event,
  output logic                       osc_pins_dedicated,
  output logic                       overflow_irq,
  output logic                       wake_request,
  output tmc_pkg::tmc_time_base_t    time_base_sel,
  output logic [15:0]                time_base_count,
  output logic                       time_base_valid
);
  import tmc_pkg::*;

  if (CLK_PER_PHASE < 1) begin : g_bad_phase_length
    $error("CLK_PER_PHASE must be at least one");
  end

  typedef enum logic [1:0] {
    TMC_PH_Q1 = 2'b00,
    TMC_PH_Q2 = 2'b01,
    TMC_PH_Q3 = 2'b10,
    TMC_PH_Q4 = 2'b11
  } tmc_phase_t;

  logic [7:0]  control_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0]  high_buf_reg;
  logic        overflow_flag_reg;
  logic        overflow_irq_enable_reg;
  logic [2:0]  prescale_reg;
  logic        ext_in;
  logic        ext_prev_reg;
  logic        armed_reg;
  logic        ps_out;
  logic        ps_prev_reg;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        sync_pend_reg;
  logic        unsync_pend_reg;
  logic        ext_rise;
  logic        inc;
  logic        wrap_now;
  logic        wr_low;
  logic        wr_high;
  logic        event_reset;
  tmc_phase_t  phase_reg;
  logic [$clog2(CLK_PER_PHASE+1)-1:0] phase_cnt_reg;
  logic        phase_step;
  logic        run;
  logic        ext_sel;
  logic        unsync;
  logic        wide;
  logic [1:0]  ps_sel;

  assign run     = control_reg[BIT_RUN_ENABLE];
  assign ext_sel = control_reg[BIT_CLOCK_SRC];
  assign unsync  = ext_sel & control_reg[BIT_SYNC_DIS];
  assign wide    = control_reg[BIT_WIDE_ACCESS];
  assign ps_sel  = {control_reg[BIT_PRESCALE_HI], control_reg[BIT_PRESCALE_LO]};
  assign wr_low  = bus_req.wr & (bus_req.addr == ADDR_COUNT_LOW);
  assign wr_high = bus_req.wr & (bus_req.addr == ADDR_COUNT_HI);

  //////////////////////////////////////////////////////////////////////////////
  // Four phase clocks derived from the one clock by an enable divider.
  assign phase_step = (phase_cnt_reg == ($clog2(CLK_PER_PHASE+1))'(CLK_PER_PHASE - 1));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_cnt_reg <= '0;
      phase_reg     <= TMC_PH_Q1;
    end else if (phase_step) begin
      phase_cnt_reg <= '0;
      case (phase_reg)
        TMC_PH_Q1: phase_reg <= TMC_PH_Q2;
        TMC_PH_Q2: phase_reg <= TMC_PH_Q3;
        TMC_PH_Q3: phase_reg <= TMC_PH_Q4;
        TMC_PH_Q4: phase_reg <= TMC_PH_Q1;
        default:   phase_reg <= TMC_PH_Q1;
      endcase
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External input selection and edge qualification.
  assign ext_in = aux_osc_enable ? aux_osc_input_pin : shared_count_clock_pin;
  assign osc_pins_dedicated = aux_osc_enable;
  assign ext_rise = ext_in & ~ext_prev_reg & armed_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_prev_reg <= 1'b0;
      armed_reg    <= 1'b0;
    end else begin
      ext_prev_reg <= ext_in;
      // A falling edge must be seen first so a pin already high is not counted.
      if (!ext_sel) begin
        armed_reg <= 1'b0;
      end else if (!ext_in && ext_prev_reg) begin
        armed_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler: counts raw qualified external edges, or instruction cycles internally.
  always_ff @(posedge ref_clk) begin
    if (srst || wr_low) begin
      prescale_reg <= 3'h0;
    end else if (run && (ext_sel ? ext_rise
                                 : (phase_step && phase_reg == TMC_PH_Q4))) begin
      prescale_reg <= prescale_reg + 3'h1;
    end
  end

  // The prescaler output is a symmetric square wave except at external 1:1, where it is the armed input; its rising edge is one count.
  always_comb begin
    case (ps_sel)
      2'b00:   ps_out = ext_sel ? (ext_in & armed_reg) : prescale_reg[0];
      2'b01:   ps_out = prescale_reg[0];
      2'b10:   ps_out = prescale_reg[1];
      2'b11:   ps_out = prescale_reg[2];
      default: ps_out = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ps_prev_reg <= 1'b0;
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
    end else begin
      sync1_reg   <= ps_out;
      sync2_reg   <= sync1_reg;
      ps_prev_reg <= sync2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Increment scheduling per mode. Synchronized and internal increments wait for
  // the Q4:Q1 boundary; unsynchronized ones also take the Q2:Q3 boundary.
  logic ps_rise;
  logic at_q41;
  logic at_q23;
  logic ps_rise_raw;
  assign ps_rise     = sync2_reg & ~ps_prev_reg;
  assign ps_rise_raw = (ps_sel == 2'b00) ? ext_rise : ps_rise;
  assign at_q41      = phase_step && (phase_reg == TMC_PH_Q4);
  assign at_q23      = phase_step && (phase_reg == TMC_PH_Q2);

  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      sync_pend_reg   <= 1'b0;
      unsync_pend_reg <= 1'b0;
    end else begin
      // A new edge on a boundary cycle must not be lost to the clear of the old one.
      if (!unsync && ps_rise && !sleep_mode) begin
        sync_pend_reg <= 1'b1;
      end else if (at_q41) begin
        sync_pend_reg <= 1'b0;
      end
      if (unsync && ps_rise_raw) begin
        unsync_pend_reg <= 1'b1;
      end else if (at_q41 || at_q23) begin
        unsync_pend_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    if (!run) begin
      inc = 1'b0;
    end else if (!ext_sel) begin
      // Internally the prescaler steps with the phases, so its rollover is the count.
      case (ps_sel)
        2'b00:   inc = at_q41;
        2'b01:   inc = at_q41 && prescale_reg[0];
        2'b10:   inc = at_q41 && (&prescale_reg[1:0]);
        default: inc = at_q41 && (&prescale_reg);
      endcase
    end else if (unsync) begin
      inc = (at_q41 || at_q23) && unsync_pend_reg;
    end else begin
      inc = at_q41 && sync_pend_reg && !sleep_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter with software load and special event reset.
  assign event_reset = (control_reg[BIT_TB_HI] && unit1_mode_field == MODE_SPECIAL_EVENT
                        && unit1_event)
                     || ((control_reg[BIT_TB_HI] || control_reg[BIT_TB_LO])
                        && unit2_mode_field == MODE_SPECIAL_EVENT && unit2_event);

  always_comb begin
    count_next = count_reg;
    if (wr_low) begin
      count_next = {wide ? high_buf_reg : count_reg[15:8], bus_req.wdata};
    end else if (wr_high && !wide) begin
      count_next = {bus_req.wdata, count_reg[7:0]};
    end else if (event_reset) begin
      count_next = COUNT_RESET;
    end else if (inc) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file: control, count bytes, high buffer and status.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      control_reg <= CONTROL_RESET;
    end else if (bus_req.wr && bus_req.addr == ADDR_CONTROL) begin
      control_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      high_buf_reg <= 8'h00;
    end else if (wide && wr_high) begin
      high_buf_reg <= bus_req.wdata;
    end else if (wide && bus_req.rd && bus_req.addr == ADDR_COUNT_LOW) begin
      high_buf_reg <= count_reg[15:8];
    end
  end

  // Only an increment that really reaches the counter may count as a wrap.
  assign wrap_now = inc && !wr_low && !(wr_high && !wide) && !event_reset
                    && (count_reg == COUNT_ALL_ONES);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overflow_flag_reg <= 1'b0;
    end else if (wrap_now) begin
      overflow_flag_reg <= 1'b1;
    end else if (overflow_flag_clear ||
                 (bus_req.wr && bus_req.addr == ADDR_STATUS && !bus_req.wdata[BIT_STAT_FLAG])) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overflow_irq_enable_reg <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == ADDR_STATUS) begin
      overflow_irq_enable_reg <= bus_req.wdata[BIT_STAT_IRQ_EN];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CONTROL:   bus_rdata <= control_reg;
        ADDR_COUNT_LOW: bus_rdata <= count_reg[7:0];
        ADDR_COUNT_HI:  bus_rdata <= wide ? high_buf_reg : count_reg[15:8];
        ADDR_STATUS:    bus_rdata <= {6'h00, overflow_irq_enable_reg, overflow_flag_reg};
        default:        bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  assign overflow_irq = overflow_flag_reg & overflow_irq_enable_reg;
  assign wake_request = overflow_irq & sleep_mode & unsync;

  //////////////////////////////////////////////////////////////////////////////
  // Time base routing toward the compare units.
  always_comb begin
    time_base_sel.sel_unit1_this = control_reg[BIT_TB_HI];
    time_base_sel.sel_unit2_this = control_reg[BIT_TB_HI] | control_reg[BIT_TB_LO];
  end
  assign time_base_count = count_reg;
  assign time_base_valid = ~unsync;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_wrap;
    @(posedge ref_clk) disable iff (srst)
      (inc && !wr_low && !wr_high && !event_reset && count_reg == COUNT_ALL_ONES)
        |=> (count_reg == COUNT_RESET && overflow_flag_reg);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not zero count and set flag");

  property p_irq;
    @(posedge ref_clk) disable iff (srst)
      $rose(overflow_flag_reg)
        |-> ($past(count_reg) == COUNT_ALL_ONES && count_reg == COUNT_RESET);
  endproperty
  a_irq: assert property (p_irq) else $error("flag set without a wrap");

  property p_stop;
    @(posedge ref_clk) disable iff (srst)
      (!run && !bus_req.wr && !event_reset) |=> $stable(count_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");

  property p_write_wins;
    @(posedge ref_clk) disable iff (srst)
      (wr_low && event_reset) |=> (count_reg[7:0] == $past(bus_req.wdata));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("reset beat the write");

  property p_event_reset;
    @(posedge ref_clk) disable iff (srst)
      (event_reset && !bus_req.wr && !overflow_flag_reg)
        |=> (count_reg == COUNT_RESET && !overflow_flag_reg);
  endproperty
  a_event_reset: assert property (p_event_reset) else $error("event reset wrong");

  property p_prescale_clear;
    @(posedge ref_clk) disable iff (srst)
      wr_low |=> (prescale_reg == 3'h0);
  endproperty
  a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler not cleared");

  property p_sync_phase;
    @(posedge ref_clk) disable iff (srst)
      (inc && !unsync) |-> (phase_reg == TMC_PH_Q4 && phase_step);
  endproperty
  a_sync_phase: assert property (p_sync_phase) else $error("sync increment off Q4:Q1");

  property p_sleep_hold;
    @(posedge ref_clk) disable iff (srst)
      (sleep_mode && ext_sel && !unsync && !bus_req.wr && !event_reset)
        |=> $stable(count_reg);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sync count moved in sleep");

  property p_time_base;
    @(posedge ref_clk) disable iff (srst)
      (unsync |-> !time_base_valid) and
      (time_base_sel.sel_unit1_this |-> time_base_sel.sel_unit2_this);
  endproperty
  a_time_base: assert property (p_time_base) else $error("time base routing wrong");

endmodule // tmc_timer

// >>> test/test_tmc_timer.sv
// Self-checking testbench of the sixteen-bit timer/counter.
`define CHK(what, exp, got) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
  end \
end
module test_tmc_timer;
  import tmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic           ref_clk = 1'b0;
  logic           srst = 1'b1;
  tmc_bus_req_t   bus_req = '0;
  logic [7:0]     bus_rdata;
  logic           aux_osc_enable;
  logic           aux_osc_input_pin;
  logic           shared_count_clock_pin;
  logic           sleep_mode = 1'b0;
  logic           overflow_flag_clear = 1'b0;
  logic [3:0]     unit1_mode_field = 4'h0;
  logic [3:0]     unit2_mode_field = 4'h0;
  logic           unit1_event = 1'b0;
  logic           unit2_event = 1'b0;
  logic           osc_pins_dedicated;
  logic           overflow_irq;
  logic           wake_request;
  tmc_time_base_t time_base_sel;
  logic [15:0]    time_base_count;
  logic           time_base_valid;
  logic [7:0]     rd_val;
  int             errors = 0;
  int             cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  tmc_timer #(.CLK_PER_PHASE(1)) dut (.ref_clk, .srst, .bus_req, .bus_rdata, .aux_osc_enable,
    .aux_osc_input_pin, .shared_count_clock_pin, .sleep_mode, .overflow_flag_clear,
    .unit1_mode_field, .unit2_mode_field, .unit1_event, .unit2_event, .osc_pins_dedicated,
    .overflow_irq, .wake_request, .time_base_sel, .time_base_count, .time_base_valid);
  tmc_ext_clock_model src (.ref_clk, .aux_osc_enable, .aux_osc_input_pin,
    .shared_count_clock_pin);
  //////////////////////////////////////////////////////////////////////////////
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
  endtask
  // Read data stand for one cycle only, so they are taken just after the answering edge.
  task automatic read_check(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    rd_val = bus_rdata;
    `CHK(what, exp, rd_val)
  endtask
  task automatic fire_event(input logic u1, input logic u2, input logic with_write);
    @(posedge ref_clk);
    unit1_event <= u1;
    unit2_event <= u2;
    if (with_write) bus_req <= '{addr: ADDR_COUNT_LOW, wdata: 8'h55, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    unit1_event <= 1'b0;
    unit2_event <= 1'b0;
    bus_req <= '0;
    #1;
  endtask
  task automatic load_count(input logic [7:0] ctl, input logic [15:0] v);
    reg_write(ADDR_CONTROL, ctl);
    reg_write(ADDR_COUNT_HI, v[15:8]);
    reg_write(ADDR_COUNT_LOW, v[7:0]);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] ctl;
    int k;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 0; a < 4; a++) read_check(a[1:0], 8'h00, "reset value");
    for (int i = 0; i < 4; i++) begin
      ctl = {1'b0, i[1], 2'b00, i[0], 3'b000};
      reg_write(ADDR_CONTROL, ctl);
      read_check(ADDR_CONTROL, ctl, "control readback");
      `CHK("time base select", {i[1], i[1] | i[0]}, time_base_sel)
    end
    $display("test time base done");
    reg_write(ADDR_CONTROL, 8'h34);
    settle(40);
    `CHK("stopped count", 16'h0000, time_base_count)
    for (int p = 0; p < 4; p++) begin
      load_count(8'h00, 16'h0000);
      reg_write(ADDR_CONTROL, {2'b00, p[1:0], 4'b0101});
      settle(12 << p);
      `CHK("prescaled count", 1'b1, time_base_count inside {16'h0002, 16'h0003})
    end
    $display("test prescale done");
    load_count(8'h00, 16'hFFFC);
    reg_write(ADDR_STATUS, 8'h02);
    `CHK("irq before wrap", 1'b0, overflow_irq)
    reg_write(ADDR_CONTROL, 8'h01);
    k = 0;
    while (overflow_irq !== 1'b1 && k < 100) begin
      settle(1);
      k++;
    end
    `CHK("count at wrap", 1'b1, time_base_count inside {16'h0000, 16'h0001})
    reg_write(ADDR_CONTROL, 8'h00);
    reg_write(ADDR_STATUS, 8'h01);
    read_check(ADDR_STATUS, 8'h01, "flag latched");
    `CHK("irq masked", 1'b0, overflow_irq)
    @(posedge ref_clk);
    overflow_flag_clear <= 1'b1;
    @(posedge ref_clk);
    overflow_flag_clear <= 1'b0;
    read_check(ADDR_STATUS, 8'h00, "flag cleared");
    $display("test overflow done");
    load_count(8'h08, 16'h1234);
    @(posedge ref_clk);
    unit1_mode_field <= MODE_SPECIAL_EVENT;
    unit2_mode_field <= MODE_SPECIAL_EVENT;
    fire_event(1'b1, 1'b0, 1'b0);
    `CHK("unit1 needs bit6", 16'h1234, time_base_count)
    fire_event(1'b0, 1'b1, 1'b1);
    `CHK("write beats event", 16'h1255, time_base_count)
    fire_event(1'b0, 1'b1, 1'b0);
    `CHK("unit2 event reset", 16'h0000, time_base_count)
    read_check(ADDR_STATUS, 8'h00, "no flag on event");
    load_count(8'h40, 16'h0077);
    @(posedge ref_clk);
    unit1_mode_field <= 4'hA;
    fire_event(1'b1, 1'b0, 1'b0);
    `CHK("other mode ignored", 16'h0077, time_base_count)
    @(posedge ref_clk);
    unit1_mode_field <= MODE_SPECIAL_EVENT;
    fire_event(1'b1, 1'b0, 1'b0);
    `CHK("unit1 event reset", 16'h0000, time_base_count)
    $display("test event reset done");
    reg_write(ADDR_CONTROL, 8'h80);
    reg_write(ADDR_COUNT_HI, 8'hAB);
    `CHK("high byte buffered", 16'h0000, time_base_count)
    reg_write(ADDR_COUNT_LOW, 8'hCD);
    `CHK("wide load", 16'hABCD, time_base_count)
    reg_write(ADDR_COUNT_HI, 8'h11);
    read_check(ADDR_COUNT_LOW, 8'hCD, "wide low read");
    read_check(ADDR_COUNT_HI, 8'hAB, "wide high read");
    $display("test wide access done");
    load_count(8'h00, 16'h0000);
    reg_write(ADDR_CONTROL, 8'h03);
    src.send_pulses(4, 4);
    settle(8);
    `CHK("first rise skipped", 16'h0003, time_base_count)
    src.select_source(1'b1);
    src.send_pulses(2, 4);
    settle(8);
    `CHK("oscillator pin count", 16'h0005, time_base_count)
    `CHK("pins dedicated", 1'b1, osc_pins_dedicated)
    @(posedge ref_clk);
    sleep_mode <= 1'b1;
    src.send_pulses(2, 4);
    settle(8);
    `CHK("sync sleep holds", 16'h0005, time_base_count)
    load_count(8'h06, 16'hFFFE);
    reg_write(ADDR_STATUS, 8'h02);
    reg_write(ADDR_CONTROL, 8'h07);
    `CHK("unsync no time base", 1'b0, time_base_valid)
    src.send_pulses(2, 4);
    settle(8);
    `CHK("unsync sleep count", 16'h0000, time_base_count)
    `CHK("wake on overflow", 1'b1, wake_request)
    @(posedge ref_clk);
    sleep_mode <= 1'b0;
    load_count(8'h00, 16'h0000);
    reg_write(ADDR_CONTROL, 8'h13);
    src.send_pulses(5, 4);
    settle(8);
    `CHK("external prescaled", 16'h0002, time_base_count)
    $display("test external clock done");
    tally_and_finish();
  end
endmodule // test_tmc_timer

// >>> test/tmc_ext_clock_model.sv
// External count source: selected clock pin, noisy unselected pin, and the oscillator enable.
module tmc_ext_clock_model (
  input  wire logic ref_clk,
  output logic      aux_osc_enable,
  output logic      aux_osc_input_pin,
  output logic      shared_count_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic level_reg = 1'b0;
  logic noise_reg = 1'b0;
  initial aux_osc_enable = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // The pin that is not selected toggles every cycle, so a design that reads it miscounts.
  always @(posedge ref_clk) begin
    noise_reg <= ~noise_reg;
  end
  assign aux_osc_input_pin      = aux_osc_enable ? level_reg : noise_reg;
  assign shared_count_clock_pin = aux_osc_enable ? noise_reg : level_reg;
  //////////////////////////////////////////////////////////////////////////////
  task automatic select_source(input logic use_osc);
    @(posedge ref_clk);
    aux_osc_enable <= use_osc;
  endtask
  // High and low phases each last the given number of cycles; four or more suits every prescale.
  task automatic send_pulses(input int count, input int half_cycles);
    repeat (count) begin
      @(posedge ref_clk);
      level_reg <= 1'b1;
      repeat (half_cycles) @(posedge ref_clk);
      level_reg <= 1'b0;
      repeat (half_cycles - 1) @(posedge ref_clk);
    end
  endtask
endmodule // tmc_ext_clock_model
